// ---- core/i2c_strap_target.sv ----
// i2c target port with strap-derived address and clock stretching
// assumes open-drain pins resolved outside; analog class from an adc
`timescale 1ns/1ps
`default_nettype none
`include "i2c_addr_params.svh"
module i2c_strap_target
	import i2c_addr_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 srst_i,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      scl_oe_n_o,
	output logic                      sda_oe_n_o,
	output logic                      scl_o,
	output logic                      sda_o,
	input  wire logic                 digital_strap_a_i,
	input  wire logic                 digital_strap_b_i,
	input  wire logic [`CLASS_W-1:0]  strap_class_i,
	input  wire logic                 class_valid_i,
	input  wire logic [6:0]           fw_mask_i,
	input  wire logic [6:0]           fw_addr_i,
	input  wire logic                 app_ready_i,
	input  wire logic [7:0]           rd_data_i,
	output logic                      addr_ready_o,
	output logic [6:0]                own_addr_o,
	output logic                      cmd_valid_o,
	output logic [7:0]                cmd_o,
	output logic                      wr_valid_o,
	output logic [7:0]                wr_data_o,
	output logic                      rd_req_o
);
	typedef struct packed {
		bus_state_t        st;
		logic              booted;
		logic [6:0]        strap;
		logic [`BIT_W-1:0] bitn;
		logic [7:0]        sh;
		logic              rnw;
		logic              sda_low;
		logic              scl_low;
		logic [7:0]        cnt;
		logic              scl_p;
		logic              sda_p;
		logic              ack_sub;
		logic              cmd_v;
		logic [7:0]        cmd;
		logic              wr_v;
		logic [7:0]        wr;
		logic              rd_r;
	} state_t;
	state_t s_q, s_d;
	logic scl_s, sda_s;
	logic strap_a_s, strap_b_s;
	pin_sync3 #(.INIT(1'b1)) u_scl (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(scl_i),
		.level_o(scl_s));
	pin_sync3 #(.INIT(1'b1)) u_sda (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(sda_i),
		.level_o(sda_s));
	// strap pins are board levels, filtered like the bus lines
	pin_sync3 #(.INIT(1'b0)) u_strap_a (.mclk_i(mclk_i), .srst_i(srst_i),
		.pin_i(digital_strap_a_i), .level_o(strap_a_s));
	pin_sync3 #(.INIT(1'b0)) u_strap_b (.mclk_i(mclk_i), .srst_i(srst_i),
		.pin_i(digital_strap_b_i), .level_o(strap_b_s));

	function automatic logic [2:0] decode_class(input logic [`CLASS_W-1:0] c);
		// class 0 ground, 1..6 resistor ladder, 7 open pin
		if (c == `CLASS_OPEN) begin
			decode_class = `ANA_CODE_OPEN;
		end else begin
			decode_class = c;
		end
	endfunction

	logic [6:0] eff_addr;
	logic       rise, fall, start_c, stop_c;
	always_comb begin
		eff_addr = (s_q.strap & ~fw_mask_i) | (fw_addr_i & fw_mask_i);
		rise     = scl_s & ~s_q.scl_p;
		fall     = ~scl_s & s_q.scl_p;
		start_c  = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
		stop_c   = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
		s_d       = s_q;
		s_d.scl_p = scl_s;
		s_d.sda_p = sda_s;
		s_d.cmd_v = 1'b0;
		s_d.wr_v  = 1'b0;
		s_d.rd_r  = 1'b0;
		if (!s_q.booted) begin
			if (s_q.cnt != 8'h00) begin
				s_d.cnt = s_q.cnt - 8'h01;
			end else if (class_valid_i) begin
				// straps and analog code taken in one cycle, then frozen
				s_d.strap  = {`ADDR_PREFIX_B7, `ADDR_PREFIX_B6, strap_b_s,
					strap_a_s, decode_class(strap_class_i)};
				s_d.booted = 1'b1;
			end
		end else begin
			if (s_q.scl_low) begin
				// hold scl low while the application side is busy
				if (s_q.cnt != 8'h00) begin
					s_d.cnt = s_q.cnt - 8'h01;
				end else if (app_ready_i) begin
					s_d.scl_low = 1'b0;
				end
			end
			if (start_c) begin
				s_d.st = ST_ADDR;
				s_d.bitn = '0;
				s_d.sda_low = 1'b0;
			end else if (stop_c) begin
				s_d.st = ST_IDLE;
				s_d.sda_low = 1'b0;
				s_d.scl_low = 1'b0;
			end else if (rise && s_q.st inside {ST_ADDR, ST_SUB, ST_WDATA}) begin
				s_d.sh = {s_q.sh[6:0], sda_s};
				s_d.bitn = s_q.bitn + 4'h1;
			end else if (rise && s_q.st == ST_MACK) begin
				s_d.st = sda_s ? ST_IDLE : ST_RDATA; // nack ends reading
				s_d.bitn = '0;
				// next byte asked for by the strobe at stretch start
				s_d.sh = rd_data_i;
			end else if (fall) begin
				unique case (s_q.st)
					ST_IDLE: begin
					end
					ST_ADDR, ST_SUB, ST_WDATA: begin
						if (s_q.bitn == `BITS_PER_BYTE) begin
							s_d.bitn = '0;
							s_d.scl_low = 1'b1;
							s_d.cnt = `STRETCH_CYC;
							if (s_q.st == ST_ADDR) begin
								if (s_q.sh[7:1] == eff_addr) begin
									s_d.sda_low = 1'b1;
									s_d.rnw = s_q.sh[0];
									s_d.ack_sub = 1'b0;
									s_d.st = ST_ACK;
									s_d.rd_r = s_q.sh[0];
								end else begin
									s_d.st = ST_IDLE;
									s_d.scl_low = 1'b0;
								end
							end else begin
								s_d.sda_low = 1'b1;
								s_d.ack_sub = 1'b1;
								s_d.st = ST_ACK;
								if (s_q.st == ST_SUB) begin
									s_d.cmd_v = 1'b1;
									s_d.cmd = s_q.sh;
								end else begin
									s_d.wr_v = 1'b1;
									s_d.wr = s_q.sh;
								end
							end
						end
					end
					ST_ACK: begin
						s_d.sda_low = 1'b0;
						if (s_q.rnw) begin
							s_d.st = ST_RDATA;
							s_d.sh = rd_data_i;
							s_d.sda_low = ~rd_data_i[7];
							s_d.bitn = 4'h1;
						end else begin
							s_d.st = s_q.ack_sub ? ST_WDATA : ST_SUB;
						end
					end
					ST_RDATA: begin
						if (s_q.bitn == `BITS_PER_BYTE) begin
							s_d.sda_low = 1'b0;
							s_d.st = ST_MACK;
							s_d.scl_low = 1'b1;
							s_d.cnt = `STRETCH_CYC;
							s_d.rd_r = 1'b1;
						end else begin
							s_d.sda_low = ~s_q.sh[3'(7 - s_q.bitn)];
							s_d.bitn = s_q.bitn + 4'h1;
						end
					end
					ST_MACK: begin
					end
					default: begin
						s_d.st = ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.cnt <= `BOOT_SETTLE_CYC;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// pins driven low only; enables active low while driving
	assign scl_oe_n_o   = ~s_q.scl_low;
	assign sda_oe_n_o   = ~s_q.sda_low;
	assign scl_o        = 1'b0;
	assign sda_o        = 1'b0;
	assign addr_ready_o = s_q.booted;
	assign own_addr_o   = s_q.strap;
	assign cmd_valid_o  = s_q.cmd_v;
	assign cmd_o        = s_q.cmd;
	assign wr_valid_o   = s_q.wr_v;
	assign wr_data_o    = s_q.wr;
	assign rd_req_o     = s_q.rd_r;

	AST_SILENT_BEFORE_BOOT: assert property (@(posedge mclk_i) disable iff (srst_i)
		!s_q.booted |-> (sda_oe_n_o && scl_oe_n_o))
		else $error("bus driven before address fixed");
	AST_ADDR_HELD: assert property (@(posedge mclk_i) disable iff (srst_i)
		s_q.booted |=> (own_addr_o == $past(own_addr_o)))
		else $error("strap address changed after boot");
	AST_PREFIX: assert property (@(posedge mclk_i) disable iff (srst_i)
		s_q.booted |-> (own_addr_o[6:5] == 2'b01))
		else $error("address prefix wrong");
	AST_STRETCH_MIN: assert property (@(posedge mclk_i) disable iff (srst_i)
		$rose(s_q.scl_low) |-> s_q.scl_low [*4])
		else $error("stretch shorter than minimum");
	AST_ACK_MATCH: assert property (@(posedge mclk_i) disable iff (srst_i)
		(s_q.st == ST_ACK && !s_q.ack_sub) |-> !sda_oe_n_o)
		else $error("matched address not acknowledged");
	AST_CMD_FROM_SUB: assert property (@(posedge mclk_i) disable iff (srst_i)
		cmd_valid_o |-> $past(s_q.st) == ST_SUB)
		else $error("command strobe outside sub-address byte");
	AST_STRETCH_AT_ACK: assert property (@(posedge mclk_i) disable iff (srst_i)
		$rose(s_q.scl_low) |-> s_q.st inside {ST_ACK, ST_MACK})
		else $error("stretch outside ack interval");
	AST_MASK: assert property (@(posedge mclk_i) disable iff (srst_i)
		(s_q.st == ST_ACK && !s_q.ack_sub) |->
		((((s_q.sh[7:1] ^ fw_addr_i) & fw_mask_i) == 7'h00) &&
		(((s_q.sh[7:1] ^ s_q.strap) & ~fw_mask_i) == 7'h00)))
		else $error("masked bit not overridden");
endmodule // i2c_strap_target
`default_nettype wire

// ---- core/i2c_addr_params.svh ----
// constants for the strap-addressed i2c target
// assumes inclusion by name from core/ files
`ifndef I2C_ADDR_PARAMS_SVH
`define I2C_ADDR_PARAMS_SVH
`define ADDR_PREFIX_B7     1'b0
`define ADDR_PREFIX_B6     1'b1
`define CLASS_W            3
`define CLASS_OPEN         3'h7
`define ANA_CODE_OPEN      3'h7
`define BOOT_SETTLE_CYC    8'h10
`define STRETCH_CYC        8'h04
`define BIT_W              4
`define BITS_PER_BYTE      4'h8
`endif

// ---- core/i2c_addr_pkg.sv ----
// types for the strap-addressed i2c target
// assumes no surroundings
package i2c_addr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_SUB   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_ACK   = 3'b101,
		ST_MACK  = 3'b110
	} bus_state_t;
endpackage

// ---- core/pin_sync3.sv ----
// three-stage pin synchroniser with agreement filter
// assumes srst_i synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter logic INIT = 1'b1
) (
	input  wire logic mclk_i,
	input  wire logic srst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] sh_q;
	logic       lvl_q;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sh_q  <= {3{INIT}};
			lvl_q <= INIT;
		end else begin
			sh_q <= {sh_q[1:0], pin_i};
			// change counts only when stages two and three agree
			if (sh_q[1] == sh_q[2]) begin
				lvl_q <= sh_q[2];
			end
		end
	end
	assign level_o = lvl_q;
endmodule // pin_sync3
`default_nettype wire

// ---- verification/i2c_master_model.sv ----
// behavioural i2c bus master on open-drain lines
// assumes the bench resolves pull-ups into scl_i and sda_i
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic mclk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	localparam int HI_CYC = 100; // 4 us at 25 MHz
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic wait_hi();
		int n;
		n = 0;
		scl_low_o <= 1'b0;
		while (scl_i !== 1'b1 && n < 5000) begin
			@(posedge mclk_i);
			n++;
		end
		repeat (HI_CYC) @(posedge mclk_i);
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda_low_o <= ~b;
		repeat (20) @(posedge mclk_i);
		wait_hi();
		r = sda_i;
		scl_low_o <= 1'b1;
		repeat (20) @(posedge mclk_i);
	endtask
	task automatic start();
		wait_hi();
		sda_low_o <= 1'b1;
		repeat (HI_CYC) @(posedge mclk_i);
		scl_low_o <= 1'b1;
		repeat (20) @(posedge mclk_i);
	endtask
	task automatic stop();
		sda_low_o <= 1'b1;
		repeat (20) @(posedge mclk_i);
		wait_hi();
		sda_low_o <= 1'b0;
		repeat (HI_CYC) @(posedge mclk_i);
	endtask
	// rel 1 releases sda in the ack slot
	task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(rel, ack);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// ---- verification/tb_i2c_strap_target.sv ----
// self-checking bench for the strap-addressed i2c target
// assumes pull-ups on both lines and the master model as bus partner
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_strap_target;
	logic       mclk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic       sa = 1'b0, sb = 1'b0, cv = 1'b0, ar = 1'b1;
	logic [2:0] cls = 3'h1;
	logic [6:0] fm = 7'h00, fa = 7'h00, own;
	logic [7:0] rdd = 8'h00, rx, cmd, wrd, cmd_q, wr_q;
	logic       ack, scl_oen, sda_oen, m_scl, m_sda, rdy, cmdv, wrv, rdq;
	int         n_fail = 0, checks_done = 0, n_rd = 0;
	wire        scl = ~(m_scl | ~scl_oen);
	wire        sda = ~(m_sda | ~sda_oen);
	always #20 mclk_i = ~mclk_i;
	i2c_master_model m (.mclk_i(mclk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
		.sda_low_o(m_sda));
	i2c_strap_target uut (.mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
		.scl_oe_n_o(scl_oen), .sda_oe_n_o(sda_oen), .scl_o(), .sda_o(),
		.digital_strap_a_i(sa), .digital_strap_b_i(sb), .strap_class_i(cls),
		.class_valid_i(cv), .fw_mask_i(fm), .fw_addr_i(fa), .app_ready_i(ar),
		.rd_data_i(rdd), .addr_ready_o(rdy), .own_addr_o(own), .cmd_valid_o(cmdv),
		.cmd_o(cmd), .wr_valid_o(wrv), .wr_data_o(wrd), .rd_req_o(rdq));
	always @(posedge mclk_i) begin
		if (cmdv === 1'b1) cmd_q <= cmd;
		if (wrv === 1'b1) wr_q <= wrd;
		if (rdq === 1'b1) n_rd <= n_rd + 1;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic t_early();
		repeat (10) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (40) @(posedge mclk_i);
		m.start();
		m.xfer(8'h42, 1'b1, rx, ack);
		m.stop();
		chk({7'h00, ack}, 8'h01);
		cv <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk({7'h00, rdy}, 8'h01);
		$display("test early done");
	endtask
	task automatic t_write();
		int n;
		n = 0;
		ar <= 1'b0;
		m.start();
		fork
			m.xfer(8'h42, 1'b1, rx, ack);
			begin
				while (scl_oen !== 1'b0 && n < 3000) begin
					@(posedge mclk_i);
					n++;
				end
				repeat (300) @(posedge mclk_i);
				chk({7'h00, scl_oen}, 8'h00);
				chk({7'h00, sda_oen}, 8'h00);
				ar <= 1'b1;
			end
		join
		chk({7'h00, ack}, 8'h00);
		m.xfer(8'h5a, 1'b1, rx, ack);
		chk(cmd_q, 8'h5a);
		m.xfer(8'hc3, 1'b1, rx, ack);
		chk(wr_q, 8'hc3);
		m.stop();
		$display("test write done");
	endtask
	task automatic t_read();
		rdd <= 8'h96;
		m.start();
		m.xfer(8'h43, 1'b1, rx, ack);
		chk({7'h00, ack}, 8'h00);
		fork
			m.xfer(8'hff, 1'b0, rx, ack);
			begin
				@(posedge mclk_i);
				while (rdq !== 1'b1) @(posedge mclk_i);
				rdd <= 8'h3c;
			end
		join
		chk(rx, 8'h96);
		m.xfer(8'hff, 1'b1, rx, ack);
		chk(rx, 8'h3c);
		chk({7'h00, n_rd == 3}, 8'h01);
		m.stop();
		$display("test read done");
	endtask
	task automatic t_mask();
		fm <= 7'h7f;
		fa <= 7'h35;
		m.start();
		m.xfer(8'h42, 1'b1, rx, ack);
		m.stop();
		chk({7'h00, ack}, 8'h01);
		m.start();
		m.xfer(8'h6a, 1'b1, rx, ack);
		m.stop();
		chk({7'h00, ack}, 8'h00);
		fm <= 7'h00;
		$display("test mask done");
	endtask
	task automatic t_straps();
		for (int i = 0; i < 32; i++) begin
			srst_i <= 1'b1;
			cv <= 1'b0;
			cls <= i[2:0];
			sa <= i[3];
			sb <= i[4];
			repeat (2) @(posedge mclk_i);
			srst_i <= 1'b0;
			repeat (20) @(posedge mclk_i);
			cv <= 1'b1;
			repeat (3) @(posedge mclk_i);
			chk({2'b00, 1'b1, i[4], i[3], i[2:0]}, {1'b0, own});
		end
		sa <= 1'b0;
		cls <= 3'h2;
		repeat (50) @(posedge mclk_i);
		chk({1'b0, own}, 8'h3f);
		$display("test straps done");
	endtask
	initial begin
		t_early();
		t_write();
		t_read();
		t_mask();
		t_straps();
		test_done();
	end
	initial begin
		repeat (40000) @(posedge mclk_i);
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end
endmodule // tb_i2c_strap_target
`default_nettype wire
